// ---- inc/flash_host_consts.svh ----
// Purpose: offsets, fields, command codes and timing counts of the flash host controller
// Assumes: 250 MHz clock
// Notes:   times are in ns, converted to cycles by rounding up
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH

`define CLK_PERIOD_NS     4
`define NS_TO_CYC(ns)     (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_AS_NS           10
`define T_WP_NS           200
`define T_WPH_NS          200
`define T_DH_NS           10
`define T_ACC_NS          200
`define T_DF_NS           50
`define T_GLITCH_NS       15
`define T_POR_NS          10000000
`define CYC_AS            `NS_TO_CYC(`T_AS_NS)
`define CYC_WP            `NS_TO_CYC(`T_WP_NS)
`define CYC_WPH           `NS_TO_CYC(`T_WPH_NS)
`define CYC_DH            `NS_TO_CYC(`T_DH_NS)
`define CYC_ACC           `NS_TO_CYC(`T_ACC_NS)
`define CYC_DF            `NS_TO_CYC(`T_DF_NS)
`define CYC_GLITCH        `NS_TO_CYC(`T_GLITCH_NS)
`define CYC_POR           `NS_TO_CYC(`T_POR_NS)

`define REG_CTRL          8'h00
`define REG_ADDR          8'h04
`define REG_WDATA         8'h08
`define REG_STATUS        8'h0C
`define REG_RDATA         8'h10
`define CTRL_RESET_VAL    32'h0000_0000
`define CTRL_CMD_LSB      0
`define CTRL_GO_BIT       8
`define CTRL_RST_BIT      16
`define CTRL_HV_RST_BIT   17
`define CTRL_HV_ID_BIT    18
`define STAT_BUSY_BIT     0
`define STAT_DONE_BIT     1
`define STAT_REFUSED_BIT  2
`define STAT_IDMODE_BIT   3
`define STAT_READY_BIT    4
`define STAT_LOCKED_BIT   5

`define UNLOCK_ADDR1      18'h05555
`define UNLOCK_ADDR2      18'h02AAA
`define LOCK_STATUS_ADDR  18'h00002
`define BOOT_LAST_ADDR    18'h01FFF
`define CODE_UNLOCK1      8'hAA
`define CODE_UNLOCK2      8'h55
`define CODE_ERASE_SETUP  8'h80
`define CODE_CHIP_ERASE   8'h10
`define CODE_SECTOR_ERASE 8'h30
`define CODE_PROGRAM      8'hA0
`define CODE_LOCKOUT      8'h40
`define CODE_ID_ENTRY     8'h90
`define CODE_ID_EXIT      8'hF0
`define POLL_BIT          7
`define TOGGLE_BIT        6
`define LOCK_BIT          0

`endif

// ---- inc/flash_host_pkg.sv ----
// Purpose: types shared by the flash host controller
// Assumes: 18-bit word address, 16-bit data
// Notes:   command codes are the values software writes to the control register
package flash_host_pkg;
   typedef enum logic [3:0] {
      CMD_READ         = 4'h0,
      CMD_PROGRAM      = 4'h1,
      CMD_CHIP_ERASE   = 4'h2,
      CMD_SECTOR_ERASE = 4'h3,
      CMD_LOCKOUT      = 4'h4,
      CMD_ID_ENTRY     = 4'h5,
      CMD_ID_EXIT3     = 4'h6,
      CMD_ID_EXIT1     = 4'h7
   } cmd_t;
   typedef enum {ST_IDLE, ST_ISSUE, ST_WAIT, ST_POLL, ST_POLL_WAIT} seq_state_t;
   typedef enum {CY_IDLE, CY_SETUP, CY_PULSE, CY_HOLD, CY_GAP} cyc_state_t;
   typedef struct packed {
      logic [17:0] addr;
      logic [15:0] data;
      logic        last;
   } step_t;
endpackage

// ---- inc/bus_cycle_if.sv ----
// Purpose: one flash bus cycle request between sequencer and pin engine
// Assumes: req is taken only while the engine is idle
// Notes:   done is a one-cycle pulse, rdata is valid with it
interface bus_cycle_if;
   logic        req;
   logic        wr;
   logic [17:0] addr;
   logic [15:0] wdata;
   logic        done;
   logic [15:0] rdata;
   modport ctl (output req, wr, addr, wdata, input done, rdata);
   modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface

// ---- hw/flash_pin_cycle.sv ----
// Purpose: drives one asynchronous read or write cycle on the flash pins
// Assumes: pins sampled synchronously to mclk_i
// Notes:   chip select is the outer strobe, write strobe or output enable the inner one
`include "flash_host_consts.svh"
module flash_pin_cycle
   import flash_host_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   bus_cycle_if.eng         cyc,
   output logic [17:0]      fl_addr_o,
   output logic [15:0]      fl_dq_o,
   output logic             fl_dq_oe_o,
   input  wire logic [15:0] fl_dq_i,
   output logic             fl_ce_b_o,
   output logic             fl_oe_b_o,
   output logic             fl_we_b_o
);
   initial begin
      if (`CYC_WP < `CYC_GLITCH + 1 || `CYC_ACC > 255) $error("Strobe timing unusable");
   end

   cyc_state_t state_reg, state_next;
   logic [7:0] cnt_reg, cnt_next;
   logic       wr_reg, wr_sel, tick, active_next;

   assign tick   = (cnt_reg == 8'h00);
   assign wr_sel = (state_reg == CY_IDLE) ? cyc.wr : wr_reg;

   always_comb begin
      state_next = state_reg;
      cnt_next   = tick ? 8'h00 : cnt_reg - 8'h01;
      case (state_reg)
         CY_IDLE: if (cyc.req) begin
            state_next = CY_SETUP;
            cnt_next   = 8'(`CYC_AS - 1);
         end
         CY_SETUP: if (tick) begin
            state_next = CY_PULSE;
            cnt_next   = wr_reg ? 8'(`CYC_WP - 1) : 8'(`CYC_ACC - 1);
         end
         CY_PULSE: if (tick) begin
            state_next = CY_HOLD;
            cnt_next   = wr_reg ? 8'(`CYC_DH - 1) : 8'(`CYC_DF - 1);
         end
         CY_HOLD: if (tick) begin
            state_next = CY_GAP;
            cnt_next   = 8'(`CYC_WPH - 1);
         end
         CY_GAP: if (tick) state_next = CY_IDLE;
         default: state_next = CY_IDLE;
      endcase
   end
   assign active_next = (state_next == CY_SETUP) || (state_next == CY_PULSE) ||
                        (state_next == CY_HOLD);

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= CY_IDLE;
         cnt_reg   <= 8'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // Registered strobes so no decode glitch reaches the pins; the write strobe
   // only falls with select low and output enable high
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fl_ce_b_o  <= 1'b1;
         fl_oe_b_o  <= 1'b1;
         fl_we_b_o  <= 1'b1;
         fl_dq_oe_o <= 1'b0;
      end else begin
         fl_ce_b_o  <= !active_next;
         fl_we_b_o  <= !(state_next == CY_PULSE && wr_sel);
         fl_oe_b_o  <= !(state_next == CY_PULSE && !wr_sel);
         fl_dq_oe_o <= active_next && wr_sel;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_reg    <= 1'b0;
         fl_addr_o <= 18'h00000;
         fl_dq_o   <= 16'h0000;
         cyc.rdata <= 16'h0000;
         cyc.done  <= 1'b0;
      end else begin
         cyc.done <= (state_reg == CY_GAP) && tick;
         if (state_reg == CY_IDLE && cyc.req) begin
            wr_reg    <= cyc.wr;
            fl_addr_o <= cyc.addr;
            fl_dq_o   <= cyc.wdata;
         end
         if (state_reg == CY_PULSE && tick && !wr_reg) cyc.rdata <= fl_dq_i;
      end
   end

   property p_inhibit;
      @(posedge mclk_i) disable iff (!rst_b_i) !fl_we_b_o |-> !fl_ce_b_o && fl_oe_b_o;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("Write strobe low while inhibited");
   property p_glitch;
      @(posedge mclk_i) disable iff (!rst_b_i) $fell(fl_we_b_o) |-> (!fl_we_b_o)[*8];
   endproperty
   a_glitch: assert property (p_glitch) else $error("Write pulse too short");
   property p_latch;
      @(posedge mclk_i) disable iff (!rst_b_i)
         !fl_we_b_o && $past(!fl_we_b_o) |-> fl_dq_oe_o && $stable(fl_addr_o) && $stable(fl_dq_o);
   endproperty
   a_latch: assert property (p_latch) else $error("Address or data moved in write");
endmodule

// ---- hw/flash_cmd_host.sv ----
// Purpose: APB-controlled host that issues command sequences to a 256K x 16 NOR flash
// Assumes: APB slave with zero wait states; flash pins synchronous to mclk_i
// Notes:   one command at a time; program and erase completion found by toggle polling, plus completion polling for programs
// How it works
// - Lockout is enabled by the six-cycle sequence ending 40 to 5555.
// - Identification by high-voltage address line or command; A0 picks code.
// - Identification entry is AA, 55, then 90 to 5555.
// - Identification exit is the three-cycle F0 form or one F0 anywhere.
// - Only the low data byte carries the command code.
// - Sector erase is the erase prefix then 30 at a sector address.
// - Chip erase is the erase prefix then 10 to 5555.
// - Address latched on last falling strobe, data on first rising.
`include "flash_host_consts.svh"
module flash_cmd_host
   import flash_host_pkg::*;
#(
   parameter int unsigned ADDR_W     = 18,
   parameter int unsigned DATA_W     = 16,
   parameter int unsigned POR_CYCLES = `CYC_POR
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic [17:0]      fl_addr_o,
   output logic [15:0]      fl_dq_o,
   output logic             fl_dq_oe_o,
   input  wire logic [15:0] fl_dq_i,
   output logic             fl_ce_b_o,
   output logic             fl_oe_b_o,
   output logic             fl_we_b_o,
   output logic             fl_reset_b_o,
   output logic             fl_reset_hv_o,
   output logic             fl_id_hv_o
);
   initial begin
      if (ADDR_W != 18 || DATA_W != 16 || POR_CYCLES < 1) $error("Unsupported parameters");
   end

   bus_cycle_if cyc ();
   flash_pin_cycle u_pins (
      .mclk_i     (mclk_i),
      .rst_b_i    (rst_b_i),
      .cyc        (cyc),
      .fl_addr_o  (fl_addr_o),
      .fl_dq_o    (fl_dq_o),
      .fl_dq_oe_o (fl_dq_oe_o),
      .fl_dq_i    (fl_dq_i),
      .fl_ce_b_o  (fl_ce_b_o),
      .fl_oe_b_o  (fl_oe_b_o),
      .fl_we_b_o  (fl_we_b_o)
   );

   seq_state_t  st_reg;
   cmd_t        cmd_reg;
   logic [31:0] ctrl_reg;
   logic [17:0] addr_reg;
   logic [15:0] wdata_reg, rdata_reg;
   logic [2:0]  step_reg;
   logic [31:0] por_cnt_reg;
   logic        por_done_reg, done_reg, refused_reg, id_mode_reg, locked_reg;
   logic        first_reg, prev_tgl_reg;
   logic        wr_en, go, boot_hit, accept, poll_ok, stable;
   step_t       step;

   // Sequences as the flash decoder expects them; any other cycle would drop it to read
   function automatic step_t seq_step(cmd_t c, logic [2:0] i, logic [17:0] a, logic [15:0] d);
      step_t s;
      s = '{addr: `UNLOCK_ADDR1, data: {8'h00, `CODE_UNLOCK1}, last: 1'b0};
      case (i)
         3'd0: if (c == CMD_ID_EXIT1) s = '{a, {8'h00, `CODE_ID_EXIT}, 1'b1};
         else if (c == CMD_READ) s = '{a, 16'h0000, 1'b1};
         3'd1, 3'd4: s = '{`UNLOCK_ADDR2, {8'h00, `CODE_UNLOCK2}, 1'b0};
         3'd2: case (c)
            CMD_PROGRAM:  s.data = {8'h00, `CODE_PROGRAM};
            CMD_ID_ENTRY: s = '{`UNLOCK_ADDR1, {8'h00, `CODE_ID_ENTRY}, 1'b1};
            CMD_ID_EXIT3: s = '{`UNLOCK_ADDR1, {8'h00, `CODE_ID_EXIT}, 1'b1};
            default:      s.data = {8'h00, `CODE_ERASE_SETUP};
         endcase
         3'd3: if (c == CMD_PROGRAM) s = '{a, d, 1'b1};
         default: case (c)
            CMD_CHIP_ERASE:   s.data = {8'h00, `CODE_CHIP_ERASE};
            CMD_SECTOR_ERASE: s = '{a, {8'h00, `CODE_SECTOR_ERASE}, 1'b1};
            default:          s.data = {8'h00, `CODE_LOCKOUT};
         endcase
      endcase
      if (i == 3'd5) s.last = 1'b1;
      return s;
   endfunction

   assign pready_o = 1'b1;
   assign wr_en    = psel_i && penable_i && pwrite_i;
   assign go       = wr_en && paddr_i == `REG_CTRL && pwdata_i[`CTRL_GO_BIT];
   // Host-side mirror of the lockout so software learns of a refused write at once;
   // the override that counts is the one written along with the command
   assign boot_hit = cmd_t'(pwdata_i[`CTRL_CMD_LSB +: 4]) == CMD_PROGRAM &&
                     addr_reg <= `BOOT_LAST_ADDR && locked_reg && !pwdata_i[`CTRL_HV_RST_BIT];
   assign accept   = go && st_reg == ST_IDLE && por_done_reg &&
                     !pwdata_i[`CTRL_RST_BIT] && !boot_hit;
   assign step     = seq_step(cmd_reg, step_reg, addr_reg, wdata_reg);
   assign stable   = cyc.rdata[`TOGGLE_BIT] == prev_tgl_reg;
   assign poll_ok  = !first_reg && stable &&
                     (cmd_reg != CMD_PROGRAM ||
                      cyc.rdata[`POLL_BIT] == wdata_reg[`POLL_BIT]);

   always_comb begin
      cyc.req   = (st_reg == ST_ISSUE) || (st_reg == ST_POLL);
      cyc.wr    = (st_reg == ST_ISSUE) && cmd_reg != CMD_READ;
      cyc.addr  = (st_reg == ST_POLL) ? addr_reg : step.addr;
      cyc.wdata = step.data;
      if (ctrl_reg[`CTRL_HV_ID_BIT] && cmd_reg == CMD_READ)
         cyc.addr = {17'h00000, addr_reg[0]};
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_reg  <= `CTRL_RESET_VAL;
         addr_reg  <= 18'h00000;
         wdata_reg <= 16'h0000;
      end else if (wr_en) begin
         case (paddr_i)
            `REG_CTRL:  ctrl_reg  <= pwdata_i & 32'h0007_000F;
            `REG_ADDR:  addr_reg  <= pwdata_i[17:0];
            `REG_WDATA: wdata_reg <= pwdata_i[15:0];
            default:    ;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prdata_o  <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else if (psel_i && !penable_i) begin
         pslverr_o <= 1'b0;
         case (paddr_i)
            `REG_CTRL:   prdata_o <= ctrl_reg;
            `REG_ADDR:   prdata_o <= {14'h0000, addr_reg};
            `REG_WDATA:  prdata_o <= {16'h0000, wdata_reg};
            `REG_STATUS: prdata_o <= {26'h0000000, locked_reg, por_done_reg, id_mode_reg,
                                      refused_reg, done_reg, st_reg != ST_IDLE};
            `REG_RDATA:  prdata_o <= {16'h0000, rdata_reg};
            default: begin
               prdata_o  <= 32'h0000_0000;
               pslverr_o <= 1'b1;
            end
         endcase
      end
   end

   // Power-on wait; counts from reset release
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         por_cnt_reg  <= 32'h0000_0000;
         por_done_reg <= 1'b0;
      end else if (!por_done_reg) begin
         por_cnt_reg  <= por_cnt_reg + 32'h0000_0001;
         por_done_reg <= por_cnt_reg == 32'(POR_CYCLES - 1);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fl_reset_b_o  <= 1'b1;
         fl_reset_hv_o <= 1'b0;
         fl_id_hv_o    <= 1'b0;
      end else begin
         fl_reset_b_o  <= !ctrl_reg[`CTRL_RST_BIT];
         fl_reset_hv_o <= ctrl_reg[`CTRL_HV_RST_BIT] && !ctrl_reg[`CTRL_RST_BIT];
         fl_id_hv_o    <= ctrl_reg[`CTRL_HV_ID_BIT];
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg       <= ST_IDLE;
         cmd_reg      <= CMD_READ;
         step_reg     <= 3'd0;
         done_reg     <= 1'b0;
         refused_reg  <= 1'b0;
         id_mode_reg  <= 1'b0;
         locked_reg   <= 1'b0;
         first_reg    <= 1'b1;
         prev_tgl_reg <= 1'b0;
         rdata_reg    <= 16'h0000;
      end else if (ctrl_reg[`CTRL_RST_BIT]) begin
         st_reg      <= ST_IDLE;
         id_mode_reg <= 1'b0;
      end else begin
         if (go) begin
            refused_reg <= !accept;
            done_reg    <= 1'b0;
         end
         if (accept) begin
            cmd_reg  <= cmd_t'(pwdata_i[`CTRL_CMD_LSB +: 4]);
            step_reg <= 3'd0;
            st_reg   <= ST_ISSUE;
         end
         case (st_reg)
            ST_IDLE:  ;
            ST_ISSUE: st_reg <= ST_WAIT;
            ST_WAIT: if (cyc.done) begin
               if (cmd_reg == CMD_READ) begin
                  rdata_reg <= cyc.rdata;
                  if (id_mode_reg && addr_reg == `LOCK_STATUS_ADDR)
                     locked_reg <= cyc.rdata[`LOCK_BIT];
               end
               if (!step.last) begin
                  step_reg <= step_reg + 3'd1;
                  st_reg   <= ST_ISSUE;
               end else if (cmd_reg inside {CMD_PROGRAM, CMD_CHIP_ERASE, CMD_SECTOR_ERASE}) begin
                  first_reg <= 1'b1;
                  st_reg    <= ST_POLL;
               end else begin
                  if (cmd_reg == CMD_LOCKOUT) locked_reg <= 1'b1;
                  if (cmd_reg == CMD_ID_ENTRY) id_mode_reg <= 1'b1;
                  if (cmd_reg inside {CMD_ID_EXIT1, CMD_ID_EXIT3}) id_mode_reg <= 1'b0;
                  done_reg <= 1'b1;
                  st_reg   <= ST_IDLE;
               end
            end
            ST_POLL: st_reg <= ST_POLL_WAIT;
            ST_POLL_WAIT: if (cyc.done) begin
               rdata_reg    <= cyc.rdata;
               prev_tgl_reg <= cyc.rdata[`TOGGLE_BIT];
               first_reg    <= 1'b0;
               if (poll_ok) begin
                  done_reg <= 1'b1;
                  st_reg   <= ST_IDLE;
               end else begin
                  st_reg <= ST_POLL;
               end
            end
            default: st_reg <= ST_IDLE;
         endcase
      end
   end

   property p_por;
      @(posedge mclk_i) disable iff (!rst_b_i) !por_done_reg |-> !cyc.req;
   endproperty
   a_por: assert property (p_por) else $error("Cycle issued during power-on wait");
   property p_first;
      @(posedge mclk_i) disable iff (!rst_b_i)
         st_reg == ST_ISSUE && step_reg == 3'd0 && !(cmd_reg inside {CMD_READ, CMD_ID_EXIT1})
         |-> cyc.addr == `UNLOCK_ADDR1 && cyc.wdata == {8'h00, `CODE_UNLOCK1};
   endproperty
   a_first: assert property (p_first) else $error("Sequence does not open with unlock");
   property p_upper;
      @(posedge mclk_i) disable iff (!rst_b_i)
         cyc.req && cyc.wr && !(cmd_reg == CMD_PROGRAM && step_reg == 3'd3)
         |-> cyc.wdata[15:8] == 8'h00;
   endproperty
   a_upper: assert property (p_upper) else $error("Command upper byte not zero");
   property p_busy;
      @(posedge mclk_i) disable iff (!rst_b_i)
         go && st_reg != ST_IDLE && !ctrl_reg[`CTRL_RST_BIT] |=> refused_reg && $stable(cmd_reg);
   endproperty
   a_busy: assert property (p_busy) else $error("Command taken while busy");
   property p_boot;
      @(posedge mclk_i) disable iff (!rst_b_i)
         go && boot_hit && st_reg == ST_IDLE && !ctrl_reg[`CTRL_RST_BIT]
         |=> refused_reg && st_reg != ST_ISSUE;
   endproperty
   a_boot: assert property (p_boot) else $error("Locked boot program issued");
   property p_hvrst;
      @(posedge mclk_i) disable iff (!rst_b_i) fl_reset_hv_o |-> fl_reset_b_o;
   endproperty
   a_hvrst: assert property (p_hvrst) else $error("Override with reset low");
   property p_hvid;
      @(posedge mclk_i) disable iff (!rst_b_i)
         ctrl_reg[`CTRL_HV_ID_BIT] && cmd_reg == CMD_READ && cyc.req && !cyc.wr
         |-> cyc.addr[17:1] == 17'h00000;
   endproperty
   a_hvid: assert property (p_hvid) else $error("Upper address set in id read");
   property p_poll;
      @(posedge mclk_i) disable iff (!rst_b_i)
         st_reg == ST_POLL_WAIT && cyc.done && !first_reg && !stable && !ctrl_reg[`CTRL_RST_BIT]
         |=> st_reg == ST_POLL ##1 cyc.req == 1'b0;
   endproperty
   a_poll: assert property (p_poll) else $error("Poll ended while toggling");
   c_program: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
      cmd_reg == CMD_PROGRAM && st_reg == ST_POLL_WAIT ##1 st_reg == ST_IDLE);
   c_id_read: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
      id_mode_reg && cmd_reg == CMD_READ && cyc.done);
   c_refused: cover property (@(posedge mclk_i) disable iff (!rst_b_i) go && !accept);
endmodule

// ---- testbench/flash_dev_model.sv ----
// Purpose: behavioural flash device behind the host pins
// Assumes: writes are taken on the rising write strobe
// Notes:   busy lasts BUSY_RD reads to keep polls short
module flash_dev_model #(
   parameter logic [15:0] MAN     = 16'h00C3, // Arbitrary value
   parameter logic [15:0] DEV     = 16'h0071, // Arbitrary value
   parameter int          BUSY_RD = 4
) (
   input  wire logic [17:0] a_i,
   input  wire logic [15:0] d_i,
   input  wire logic        ce_b_i,
   input  wire logic        oe_b_i,
   input  wire logic        we_b_i,
   input  wire logic        rst_b_i,
   input  wire logic        hv_i,
   input  wire logic        idhv_i,
   output wire logic [15:0] q_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] m [16] = '{default: 16'hFFFF};
   logic [15:0] pv = 0, lv = 0, rd;
   logic [2:0]  st = 0;
   logic        idm = 0, tg = 0, er = 0;
   logic        lk = 0;
   int          bc = 0;
   wire logic [7:0] c = d_i[7:0];
   wire logic       u = a_i == 18'h05555;
   wire logic       v = a_i == 18'h02AAA;
   always @(negedge rst_b_i) {bc, st, idm} = '0;
   always @(posedge we_b_i) if (!ce_b_i && oe_b_i && rst_b_i && bc == 0) begin
      if (c == 8'hF0) idm = 0;
      case (st)
         0: st = (u && c == 8'hAA) ? 3'd1 : 3'd0;
         1: st = (v && c == 8'h55) ? 3'd2 : 3'd0;
         2: begin
            st = (u && c == 8'h80) ? 3'd3 : (u && c == 8'hA0) ? 3'd6 : 3'd0;
            if (u && c == 8'h90) idm = 1;
         end
         3: st = (u && c == 8'hAA) ? 3'd4 : 3'd0;
         4: st = (v && c == 8'h55) ? 3'd5 : 3'd0;
         5: begin
            st = 0;
            if (u && c == 8'h40) lk = 1;
            if (u && c == 8'h10 || c == 8'h30) begin
               // Word 0 stands for the boot block
               foreach (m[i]) if (i > 0 || !lk || hv_i) m[i] = 16'hFFFF;
               er = 1;
               bc = BUSY_RD;
            end
         end
         default: begin
            st = 0;
            if (!(lk && a_i <= 18'h01FFF && !hv_i)) begin
               m[a_i[3:0]] &= d_i;
               pv = d_i;
               er = 0;
               bc = BUSY_RD;
            end
         end
      endcase
   end
   always @(negedge oe_b_i) if (!ce_b_i && bc > 0) begin
      tg = !tg;
      bc = bc - 1;
   end
   always_comb
      if (bc > 0) rd = {8'h00, er ? 1'b0 : !pv[7], tg, 6'h00};
      else if (idm || idhv_i && a_i[17:1] == 17'h0) rd = a_i[1] ? {15'h0, lk} : a_i[0] ? DEV : MAN;
      else rd = m[a_i[3:0]];
   always @(posedge oe_b_i) lv = rd;
   // A released bus shows the inverse of the last word, never a stale copy
   assign q_o = (!ce_b_i && !oe_b_i && rst_b_i) ? rd : ~lv;
endmodule

// ---- testbench/flash_command_lockout_status_tb.sv ----
// Purpose: self-checking bench for the APB flash command host
// Assumes: power-on block shortened to 40 cycles
// Notes:   every GO issued through go() is followed by a bounded busy poll
`include "flash_host_consts.svh"
module flash_command_lockout_status_tb import flash_host_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, mon = 0;
   logic        pslverr, pready, oe, ceb, oeb, web, rb, hv, ih;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, r, ev[$], mv[$];
   logic [17:0] fa;
   logic [15:0] fdo, fdi, d = 0;
   int          err_count = 0, tests_run = 0;
   flash_cmd_host #(.POR_CYCLES(40)) u_dut (.mclk_i(clk), .rst_b_i(rst_b), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .fl_addr_o(fa),
      .fl_dq_o(fdo), .fl_dq_oe_o(oe), .fl_dq_i(fdi), .fl_ce_b_o(ceb), .fl_oe_b_o(oeb),
      .fl_we_b_o(web), .fl_reset_b_o(rb), .fl_reset_hv_o(hv), .fl_id_hv_o(ih));
   // Undriven data lines reach the model inverted, so a missing output enable breaks writes
   flash_dev_model u_dev (.a_i(fa), .d_i(oe ? fdo : ~fdo), .ce_b_i(ceb), .oe_b_i(oeb),
      .we_b_i(web), .rst_b_i(rb), .hv_i(hv), .idhv_i(ih), .q_o(fdi));
   initial forever #2 clk = ~clk;
   task automatic close_out();
      if (err_count == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic c);
      int n;
      n = 0;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata, mon} <= {2'b10, w, a, wd, c};
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1 && n++ < 20);
      if (n >= 20) begin err_count++; close_out(); end
      r = prdata;
      {psel, penable, mon} <= 3'b000;
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      ev.push_back(e);
      mv.push_back(m);
      apb(0, a, 0, 1);
   endtask
   task automatic go(input logic [3:0] c, input logic [17:0] a, input logic [31:0] x);
      int n;
      n = 0;
      apb(1, `REG_ADDR, {14'h0, a}, 0);
      apb(1, `REG_WDATA, {16'h0, d}, 0);
      apb(1, `REG_CTRL, x | 32'h100 | c, 0);
      do apb(0, `REG_STATUS, 0, 0); while (r[0] !== 1'b0 && n++ < 4000);
      if (n >= 4000) begin err_count++; close_out(); end
   endtask
   always @(posedge clk) if (psel && penable && !pwrite && mon) begin
      tests_run++;
      if ((prdata & mv[0]) !== ev[0]) begin
         err_count++;
         $display("FAIL %0t got %h exp %h", $time, prdata & mv[0], ev[0]);
      end
      void'(ev.pop_front());
      void'(mv.pop_front());
   end
   initial begin
      void'($urandom(91));
      repeat (4) @(posedge clk);
      rst_b <= 1;
      go(CMD_PROGRAM, 18'h1F005, 0);
      chk(`REG_STATUS, 32'h04, 32'h14);
      repeat (50) @(posedge clk);
      chk(`REG_CTRL, 1, 32'hFFFF_FFFF);
      chk(8'h20, 0, 32'hFFFF_FFFF);
      tests_run++;
      if (pslverr !== 1'b1) begin err_count++; $display("FAIL %0t %h %h", $time, pslverr, 1); end
      go(CMD_ID_ENTRY, 0, 0);
      chk(`REG_STATUS, 32'h18, 32'h18);
      go(CMD_READ, 18'h00001, 0);
      chk(`REG_RDATA, 32'h0071, 32'hFFFF);
      go(CMD_LOCKOUT, 0, 0);
      go(CMD_READ, 18'h00002, 0);
      chk(`REG_RDATA, 1, 1);
      chk(`REG_STATUS, 32'h28, 32'h28);
      go(CMD_ID_EXIT1, 18'h12345, 0);
      chk(`REG_STATUS, 0, 32'h08);
      d = 16'h00FF;
      go(CMD_PROGRAM, 18'h00100, 0);
      chk(`REG_STATUS, 32'h04, 32'h06);
      go(CMD_PROGRAM, 18'h00100, 32'h20000);
      chk(`REG_STATUS, 32'h02, 32'h06);
      d = 16'($urandom);
      go(CMD_PROGRAM, 18'h1F005, 0);
      chk(`REG_RDATA, {16'h0, d}, 32'hFFFF);
      go(CMD_SECTOR_ERASE, 18'h1F000, 0);
      chk(`REG_STATUS, 32'h02, 32'h07);
      go(CMD_READ, 18'h1F005, 0);
      chk(`REG_RDATA, 32'hFFFF, 32'hFFFF);
      apb(1, `REG_CTRL, 32'h102, 0);
      go(CMD_READ, 18'h1F005, 0);
      chk(`REG_STATUS, 32'h06, 32'h07);
      go(CMD_READ, 18'h00100, 0);
      chk(`REG_RDATA, 32'h00FF, 32'hFFFF);
      go(CMD_ID_ENTRY, 0, 0);
      go(CMD_ID_EXIT3, 0, 0);
      chk(`REG_STATUS, 0, 32'h08);
      go(CMD_ID_ENTRY, 0, 0);
      go(CMD_READ, 0, 32'h10000);
      chk(`REG_STATUS, 32'h04, 32'h0C);
      apb(1, `REG_CTRL, 0, 0);
      go(CMD_READ, 18'h00001, 0);
      chk(`REG_RDATA, 32'hFFFF, 32'hFFFF);
      go(CMD_READ, 18'h12343, 32'h40000);
      chk(`REG_RDATA, 32'h0071, 32'hFFFF);
      close_out();
   end
endmodule
